// ==== ftmc_regs.svh ====
// Register offsets, field positions, codes and lengths of the flow codec
`ifndef FTMC_REGS_SVH
`define FTMC_REGS_SVH

// APB register byte offsets
`define FTMC_TX_CMD 8'h00
`define FTMC_STATUS 8'h04
`define FTMC_MASK 8'h08
`define FTMC_CNF_CODE 8'h0C
`define FTMC_RX_TYPE 8'h10
`define FTMC_RX_DATA 8'h14

// Event bit positions in status and mask
`define FTMC_EV_END_REQ 0
`define FTMC_EV_END_CNF 1
`define FTMC_EV_BW_IND 2
`define FTMC_EV_SHIFT_REQ 3
`define FTMC_EV_PROTO_ERR 4
`define FTMC_EV_TX_DONE 5
`define FTMC_EV_COUNT 6

// Reset values
`define FTMC_MASK_RST 6'h00
`define FTMC_CNF_CODE_RST 8'h00

// Termination reason codes
`define FTMC_RSN_NORMAL 8'h00
`define FTMC_RSN_NO_RES 8'h01
`define FTMC_RSN_TUNNEL 8'h02
`define FTMC_RSN_DISCON 8'h03
`define FTMC_RSN_LAST 8'h03

// Termination result codes
`define FTMC_END_OK 8'h00
`define FTMC_END_BROKEN 8'h01
`define FTMC_END_UNKNOWN 8'h02
`define FTMC_END_LAST 8'h02

// Allocation shift confirmation code
`define FTMC_SHIFT_RECEIVED 8'h00

// Payload lengths in octets
`define FTMC_LEN_END_REQ 3'h4
`define FTMC_LEN_END_CNF 3'h3
`define FTMC_LEN_BW_IND 3'h4
`define FTMC_LEN_SHIFT_REQ 3'h4
`define FTMC_LEN_SHIFT_CNF 3'h3

`endif

// ==== ftmc_pkg.sv ====
// Types shared by both ends of the flow codec
package ftmc_pkg;

  // Management message kinds carried on the link
  typedef enum logic [2:0] {
    FTMC_END_REQ = 3'b000,
    FTMC_END_CNF = 3'b001,
    FTMC_BW_IND = 3'b010,
    FTMC_SHIFT_REQ = 3'b011,
    FTMC_SHIFT_CNF = 3'b100
  } ftmc_msg_t;

endpackage

// ==== ftmc_link_if.sv ====
// Octet link between a node and the domain master
`timescale 1ns/1ns
interface ftmc_link_if;
  logic n2m_vld;
  ftmc_pkg::ftmc_msg_t n2m_type;
  logic [7:0] n2m_octet;
  logic n2m_last;
  logic m2n_vld;
  ftmc_pkg::ftmc_msg_t m2n_type;
  logic [7:0] m2n_octet;
  logic m2n_last;

  modport node_mp (
    output n2m_vld, n2m_type, n2m_octet, n2m_last,
    input m2n_vld, m2n_type, m2n_octet, m2n_last
  );
  modport master_mp (
    input n2m_vld, n2m_type, n2m_octet, n2m_last,
    output m2n_vld, m2n_type, m2n_octet, m2n_last
  );
endinterface

// ==== ftmc_ser.sv ====
// Payload serializer: sends up to four octets, octet 0 first
`timescale 1ns/1ns
module ftmc_ser #(
  parameter int OCTETS = 4
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire ftmc_pkg::ftmc_msg_t type_in,
  input wire logic [8*OCTETS-1:0] octets_in,
  input wire logic [2:0] len_in,
  output logic busy_out,
  output logic vld_out,
  output ftmc_pkg::ftmc_msg_t type_out,
  output logic [7:0] octet_out,
  output logic last_out
);

  typedef struct packed {
    logic busy;
    logic [2:0] idx;
    logic [2:0] len;
    logic [8*OCTETS-1:0] buf_oct;
    logic vld;
    ftmc_pkg::ftmc_msg_t typ;
    logic [7:0] octet;
    logic last;
  } ftmc_ser_st_t;

  ftmc_ser_st_t q, d;

  // Start only while idle; one octet per cycle afterwards
  always_comb begin
    d = q;
    d.vld = 1'b0;
    d.last = 1'b0;
    if (!q.busy && start_in) begin
      d.busy = 1'b1;
      d.idx = 3'h0;
      d.len = len_in;
      d.buf_oct = octets_in;
      d.typ = type_in;
    end else if (q.busy) begin
      d.vld = 1'b1;
      d.octet = q.buf_oct[8*q.idx +: 8];
      d.last = (q.idx == q.len - 3'h1);
      d.idx = q.idx + 3'h1;
      if (d.last) begin
        d.busy = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy_out = q.busy;
  assign vld_out = q.vld;
  assign type_out = q.typ;
  assign octet_out = q.octet;
  assign last_out = q.last;

endmodule // ftmc_ser

// ==== ftmc_node.sv ====
// Node end: sends requests and indications, answers termination
`timescale 1ns/1ns
`include "ftmc_regs.svh"
module ftmc_node (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  ftmc_link_if.node_mp link,
  input wire logic cmd_vld_in,
  input wire ftmc_pkg::ftmc_msg_t cmd_type_in,
  input wire logic [7:0] cmd_node_in,
  input wire logic [7:0] cmd_orig_in,
  input wire logic [7:0] cmd_flow_in,
  input wire logic [15:0] cmd_val_in,
  input wire logic [7:0] end_result_in,
  output logic cmd_rdy_out,
  output logic cmd_err_out,
  output logic rx_vld_out,
  output ftmc_pkg::ftmc_msg_t rx_type_out,
  output logic [31:0] rx_data_out
);

  typedef struct packed {
    logic rdy;
    logic cerr;
    logic [2:0] rx_idx;
    logic [31:0] rx_buf;
    logic rx_vld;
    ftmc_pkg::ftmc_msg_t rx_type;
    logic [31:0] rx_data;
    logic rep_pend;
    logic [23:0] rep_oct;
    logic tx_pend;
    ftmc_pkg::ftmc_msg_t tx_type;
    logic [31:0] tx_oct;
  } ftmc_node_st_t;

  ftmc_node_st_t q, d;
  logic ser_busy;
  logic ser_start;
  logic ser_rep;
  ftmc_pkg::ftmc_msg_t ser_type;
  logic [31:0] ser_oct;
  logic [2:0] ser_len;
  logic [31:0] rx_word;

  // Replies go out before own traffic
  assign ser_rep = q.rep_pend;
  assign ser_start = !ser_busy && (q.rep_pend || q.tx_pend);
  assign ser_type = ser_rep ? ftmc_pkg::FTMC_END_CNF : q.tx_type;
  assign ser_oct = ser_rep ? {8'h00, q.rep_oct} : q.tx_oct;
  assign rx_word = q.rx_buf | ({24'h000000, link.m2n_octet}
                   << {q.rx_idx, 3'b000});

  always_comb begin
    case (q.tx_type)
      ftmc_pkg::FTMC_END_REQ: ser_len = `FTMC_LEN_END_REQ;
      ftmc_pkg::FTMC_BW_IND: ser_len = `FTMC_LEN_BW_IND;
      default: ser_len = `FTMC_LEN_SHIFT_REQ;
    endcase
    if (ser_rep) begin
      ser_len = `FTMC_LEN_END_CNF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command intake, parser and reply scheduling
  always_comb begin
    d = q;
    d.cerr = 1'b0;
    d.rx_vld = 1'b0;
    if (ser_start) begin
      if (ser_rep) begin
        d.rep_pend = 1'b0;
      end else begin
        d.tx_pend = 1'b0;
      end
    end
    if (cmd_vld_in && q.rdy) begin
      d.tx_type = cmd_type_in;
      d.tx_pend = 1'b1;
      case (cmd_type_in)
        // [RULE1] termination request layout
        ftmc_pkg::FTMC_END_REQ: begin
          d.tx_oct = {cmd_val_in[7:0], cmd_flow_in, cmd_orig_in,
                      cmd_node_in};
          // [RULE4] reserved reasons refused
          if (cmd_val_in[7:0] > `FTMC_RSN_LAST) begin
            d.tx_pend = 1'b0;
            d.cerr = 1'b1;
          end
        end
        // [RULE10] [RULE12] [RULE15] id, flow, MSB first
        ftmc_pkg::FTMC_BW_IND, ftmc_pkg::FTMC_SHIFT_REQ: begin
          d.tx_oct = {cmd_val_in[7:0], cmd_val_in[15:8], cmd_flow_in,
                      cmd_node_in};
        end
        default: begin
          d.tx_pend = 1'b0;
          d.cerr = 1'b1;
        end
      endcase
    end
    d.rdy = !d.tx_pend;
    // Octets collect until the last one of a message
    if (link.m2n_vld) begin
      d.rx_buf = rx_word;
      d.rx_idx = q.rx_idx + 3'h1;
      if (link.m2n_last) begin
        d.rx_buf = '0;
        d.rx_idx = 3'h0;
        d.rx_vld = 1'b1;
        d.rx_type = link.m2n_type;
        d.rx_data = rx_word;
        // [RULE5] [RULE6] answer with same flow
        if (link.m2n_type == ftmc_pkg::FTMC_END_REQ) begin
          d.rep_pend = 1'b1;
          d.rep_oct = {end_result_in, rx_word[23:16], rx_word[15:8]};
        end
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Shared octet sender
  ftmc_ser #(.OCTETS(4)) u_ser (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .start_in(ser_start),
    .type_in(ser_type),
    .octets_in(ser_oct),
    .len_in(ser_len),
    .busy_out(ser_busy),
    .vld_out(link.n2m_vld),
    .type_out(link.n2m_type),
    .octet_out(link.n2m_octet),
    .last_out(link.n2m_last)
  );

  assign cmd_rdy_out = q.rdy;
  assign cmd_err_out = q.cerr;
  assign rx_vld_out = q.rx_vld;
  assign rx_type_out = q.rx_type;
  assign rx_data_out = q.rx_data;

endmodule // ftmc_node

// ==== ftmc_master.sv ====
// Domain master end: APB registers, parser, replies and interrupt
//
// Notes on behaviour
// [RULE1] End request: ender, originator, flow, reason
// [RULE2] Reason 00 is ordinary originator termination
// [RULE3] Master reasons: 01 resources, 02 tunnel, 03 endpoint; the master also sends reason 00 if software writes it
// [RULE4] Reasons 04 to FF never sent
// [RULE5] Every end request answered by end confirm
// [RULE6] End confirm: originator, flow, result code
// [RULE7] Results: 00 done, 01 broken, 02 unknown
// [RULE8] Node reports bandwidth changes to master
// [RULE9] Hidden nodes also send bandwidth indication
// [RULE10] Bandwidth indication: node, flow, 16-bit request
// [RULE11] Node asks master to shift slots
// [RULE12] Shift request: node, flow, signed microseconds
// [RULE13] Master confirms each shift request
// [RULE14] Shift confirm code 00 means received
// [RULE15] Two-octet fields carry high byte first
// [RULE16] Reserved codes raise protocol error, ignored
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "ftmc_regs.svh"
module ftmc_master (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  ftmc_link_if.master_mp link,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic irq_out
);

  localparam int EV = `FTMC_EV_COUNT;

  typedef struct packed {
    logic rdy;
    logic err;
    logic [31:0] rdata;
    logic [EV-1:0] sts;
    logic [EV-1:0] msk;
    logic [7:0] cnf_code;
    logic irq;
    logic [2:0] rx_idx;
    logic [31:0] rx_buf;
    ftmc_pkg::ftmc_msg_t rx_type;
    logic [31:0] rx_data;
    logic rep_pend;
    ftmc_pkg::ftmc_msg_t rep_type;
    logic [23:0] rep_oct;
    logic tx_pend;
    logic [31:0] tx_oct;
  } ftmc_mst_st_t;

  ftmc_mst_st_t q, d;

  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic [EV-1:0] ev;
  logic [EV-1:0] clr;
  logic [31:0] rx_word;
  logic ser_busy;
  logic ser_start;
  logic ser_rep;
  ftmc_pkg::ftmc_msg_t ser_type;
  logic [31:0] ser_oct;
  logic [2:0] ser_len;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  // Setup cycle loads the answer; access completes with no wait state
  assign setup = psel_in && !penable_in;
  assign access = psel_in && penable_in && q.rdy;
  assign wr = access && pwrite_in;

  always_comb begin
    case (paddr_in)
      `FTMC_TX_CMD, `FTMC_STATUS, `FTMC_MASK, `FTMC_CNF_CODE,
      `FTMC_RX_TYPE, `FTMC_RX_DATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sender selection

  // Replies win over software traffic so a node is never left waiting
  assign ser_rep = q.rep_pend;
  assign ser_start = !ser_busy && (q.rep_pend || q.tx_pend);
  assign ser_type = ser_rep ? q.rep_type : ftmc_pkg::FTMC_END_REQ;
  assign ser_oct = ser_rep ? {8'h00, q.rep_oct} : q.tx_oct;
  assign ser_len = !ser_rep ? `FTMC_LEN_END_REQ :
                   (q.rep_type == ftmc_pkg::FTMC_END_CNF) ?
                   `FTMC_LEN_END_CNF : `FTMC_LEN_SHIFT_CNF;

  // Incoming octet merged at its position, octet 0 in the low byte
  assign rx_word = q.rx_buf | ({24'h000000, link.n2m_octet}
                   << {q.rx_idx, 3'b000});

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    d = q;
    ev = '0;
    clr = '0;
    d.rdy = setup;
    d.err = setup && !mapped;

    // Read data captured in the setup cycle
    if (setup) begin
      case (paddr_in)
        `FTMC_TX_CMD: d.rdata = {31'h0, q.tx_pend};
        `FTMC_STATUS: d.rdata = {26'h0, q.sts};
        `FTMC_MASK: d.rdata = {26'h0, q.msk};
        `FTMC_CNF_CODE: d.rdata = {24'h000000, q.cnf_code};
        `FTMC_RX_TYPE: d.rdata = {29'h0, q.rx_type};
        `FTMC_RX_DATA: d.rdata = q.rx_data;
        default: d.rdata = 32'h00000000;
      endcase
    end

    // Sender hand-off
    if (ser_start) begin
      if (ser_rep) begin
        d.rep_pend = 1'b0;
      end else begin
        d.tx_pend = 1'b0;
        ev[`FTMC_EV_TX_DONE] = 1'b1;
      end
    end

    // Register writes
    if (wr) begin
      case (paddr_in)
        `FTMC_TX_CMD: begin
          // [RULE4] reserved reasons never sent
          if (pwdata_in[31:24] > `FTMC_RSN_LAST) begin
            ev[`FTMC_EV_PROTO_ERR] = 1'b1;
          end else if (!q.tx_pend) begin
            // [RULE1] [RULE3] ender, originator, flow, reason
            d.tx_oct = pwdata_in;
            d.tx_pend = 1'b1;
          end
        end
        `FTMC_STATUS: clr = pwdata_in[EV-1:0];
        `FTMC_MASK: d.msk = pwdata_in[EV-1:0];
        `FTMC_CNF_CODE: d.cnf_code = pwdata_in[7:0];
        default: d.msk = q.msk;
      endcase
    end

    // Parser: octets gather until the last of a message
    if (link.n2m_vld) begin
      d.rx_buf = rx_word;
      d.rx_idx = q.rx_idx + 3'h1;
      if (link.n2m_last) begin
        d.rx_buf = '0;
        d.rx_idx = 3'h0;
        d.rx_type = link.n2m_type;
        d.rx_data = rx_word;
        case (link.n2m_type)
          ftmc_pkg::FTMC_END_REQ: begin
            // [RULE16] reserved reason flagged, not acted on
            if (rx_word[31:24] > `FTMC_RSN_LAST) begin
              ev[`FTMC_EV_PROTO_ERR] = 1'b1;
            end else begin
              // [RULE2] [RULE3] valid reason accepted
              ev[`FTMC_EV_END_REQ] = 1'b1;
              // [RULE5] [RULE6] [RULE7] confirm names same flow
              d.rep_pend = 1'b1;
              d.rep_type = ftmc_pkg::FTMC_END_CNF;
              d.rep_oct = {q.cnf_code, rx_word[23:16], rx_word[15:8]};
            end
          end
          ftmc_pkg::FTMC_END_CNF: begin
            // [RULE16] [RULE7] result above 02 is reserved
            if (rx_word[23:16] > `FTMC_END_LAST) begin
              ev[`FTMC_EV_PROTO_ERR] = 1'b1;
            end else begin
              ev[`FTMC_EV_END_CNF] = 1'b1;
            end
          end
          // [RULE8] [RULE10] [RULE15] request kept high byte first
          ftmc_pkg::FTMC_BW_IND: ev[`FTMC_EV_BW_IND] = 1'b1;
          ftmc_pkg::FTMC_SHIFT_REQ: begin
            // [RULE11] [RULE12] shift stored for software
            ev[`FTMC_EV_SHIFT_REQ] = 1'b1;
            // [RULE13] [RULE14] receipt confirmed, code 00
            d.rep_pend = 1'b1;
            d.rep_type = ftmc_pkg::FTMC_SHIFT_CNF;
            d.rep_oct = {`FTMC_SHIFT_RECEIVED, rx_word[15:8],
                         rx_word[7:0]};
          end
          default: ev[`FTMC_EV_PROTO_ERR] = 1'b1;
        endcase
      end
    end

    // Sticky status: a new event beats a write-one clear
    d.sts = (q.sts & ~clr) | ev;
    d.irq = |(d.sts & d.msk);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      q <= '0;
      q.msk <= `FTMC_MASK_RST;
      q.cnf_code <= `FTMC_CNF_CODE_RST;
    end else begin
      q <= d;
    end
  end

  // Octet sender toward the nodes
  ftmc_ser #(.OCTETS(4)) u_ser (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .start_in(ser_start),
    .type_in(ser_type),
    .octets_in(ser_oct),
    .len_in(ser_len),
    .busy_out(ser_busy),
    .vld_out(link.m2n_vld),
    .type_out(link.m2n_type),
    .octet_out(link.m2n_octet),
    .last_out(link.m2n_last)
  );

  assign prdata_out = q.rdata;
  assign pready_out = q.rdy;
  assign pslverr_out = q.err;
  assign irq_out = q.irq;

endmodule // ftmc_master

// ==== ftmc_link_asserts.sv ====
// Link checker: framing, codes and replies in both directions
`timescale 1ns/1ns
module ftmc_link_asserts (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic n2m_vld,
  input wire ftmc_pkg::ftmc_msg_t n2m_type,
  input wire logic [7:0] n2m_octet,
  input wire logic n2m_last,
  input wire logic m2n_vld,
  input wire ftmc_pkg::ftmc_msg_t m2n_type,
  input wire logic [7:0] m2n_octet,
  input wire logic m2n_last
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////
  // Three contiguous octets, last flag only on the third
  sequence s_three(v, l);
    v && !l ##1 v && !l ##1 v && l;
  endsequence
  // Four octets: one leading octet, then a three-octet train
  sequence s_four(v, l);
    v && !l ##1 s_three(v, l);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // Message lengths on both directions
  a_end_req_len: assert property (
    $rose(n2m_vld) && n2m_type == ftmc_pkg::FTMC_END_REQ
    |-> s_four(n2m_vld, n2m_last)) else $error("end request length");
  a_bw_ind_len: assert property (
    $rose(n2m_vld) && n2m_type == ftmc_pkg::FTMC_BW_IND
    |-> s_four(n2m_vld, n2m_last)) else $error("bandwidth length");
  a_shift_req_len: assert property (
    $rose(n2m_vld) && n2m_type == ftmc_pkg::FTMC_SHIFT_REQ
    |-> s_four(n2m_vld, n2m_last)) else $error("shift request length");
  a_end_cnf_len: assert property (
    $rose(m2n_vld) && m2n_type == ftmc_pkg::FTMC_END_CNF
    |-> s_three(m2n_vld, m2n_last)) else $error("end confirm length");
  a_shift_cnf_len: assert property (
    $rose(m2n_vld) && m2n_type == ftmc_pkg::FTMC_SHIFT_CNF
    |-> s_three(m2n_vld, m2n_last)) else $error("shift confirm length");
  // Codes carried in the final octet
  a_shift_code: assert property (
    m2n_vld && m2n_last && m2n_type == ftmc_pkg::FTMC_SHIFT_CNF
    |-> m2n_octet == 8'h00) else $error("shift confirm code");
  a_node_reason: assert property (
    n2m_vld && n2m_last && n2m_type == ftmc_pkg::FTMC_END_REQ
    |-> n2m_octet <= 8'h03) else $error("node reason reserved");
  a_master_reason: assert property (
    m2n_vld && m2n_last && m2n_type == ftmc_pkg::FTMC_END_REQ
    |-> m2n_octet inside {8'h01, 8'h02, 8'h03}) else $error("master reason");
  // Replies follow their requests within a short bound
  a_end_reply: assert property (
    n2m_vld && n2m_last && n2m_type == ftmc_pkg::FTMC_END_REQ
    && n2m_octet <= 8'h03
    |-> ##[1:10] m2n_vld && m2n_type == ftmc_pkg::FTMC_END_CNF)
    else $error("master did not confirm end");
  a_node_reply: assert property (
    m2n_vld && m2n_last && m2n_type == ftmc_pkg::FTMC_END_REQ
    |-> ##[1:10] n2m_vld && n2m_type == ftmc_pkg::FTMC_END_CNF)
    else $error("node did not confirm end");
  a_shift_reply: assert property (
    n2m_vld && n2m_last && n2m_type == ftmc_pkg::FTMC_SHIFT_REQ
    |-> ##[1:10] m2n_vld && m2n_type == ftmc_pkg::FTMC_SHIFT_CNF)
    else $error("shift not confirmed");
endmodule // ftmc_link_asserts

// ==== tb_top.sv ====
// Testbench joining the node and master ends over the octet link
`timescale 1ns/1ns
`include "ftmc_regs.svh"
module tb_top;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cmd_vld_in = 1'b0;
  ftmc_pkg::ftmc_msg_t cmd_type_in = ftmc_pkg::FTMC_END_REQ;
  logic [7:0] cmd_node_in = 8'h00;
  logic [7:0] cmd_orig_in = 8'h00;
  logic [7:0] cmd_flow_in = 8'h00;
  logic [15:0] cmd_val_in = 16'h0000;
  logic [7:0] end_result_in = 8'h00;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h00000000;
  logic cmd_rdy_out, cmd_err_out, rx_vld_out, pready_out, pslverr_out, irq_out;
  ftmc_pkg::ftmc_msg_t rx_type_out;
  logic [31:0] rx_data_out, prdata_out;
  logic [66:0] exp_q[$];
  int n_mismatch = 0;
  int num_checks = 0;
  logic [7:0] n, o, f;
  logic [15:0] v;
  logic [31:0] rw;
  logic re;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  localparam logic [31:0] LOW3 = 32'h00FFFFFF;
  ////////////////////////////////////////////////////////////////////////////
  // Clock of 10 ns
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  ftmc_link_if link ();
  ftmc_node ftmc_node_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .link(link), .cmd_vld_in(cmd_vld_in), .cmd_type_in(cmd_type_in),
    .cmd_node_in(cmd_node_in), .cmd_orig_in(cmd_orig_in),
    .cmd_flow_in(cmd_flow_in), .cmd_val_in(cmd_val_in),
    .end_result_in(end_result_in), .cmd_rdy_out(cmd_rdy_out),
    .cmd_err_out(cmd_err_out), .rx_vld_out(rx_vld_out),
    .rx_type_out(rx_type_out), .rx_data_out(rx_data_out));
  ftmc_master ftmc_master_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .link(link), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .irq_out(irq_out));
  ftmc_link_asserts ftmc_link_asserts_inst (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .n2m_vld(link.n2m_vld), .n2m_type(link.n2m_type),
    .n2m_octet(link.n2m_octet), .n2m_last(link.n2m_last),
    .m2n_vld(link.m2n_vld), .m2n_type(link.m2n_type),
    .m2n_octet(link.m2n_octet), .m2n_last(link.m2n_last));
  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks: one for link messages, one for register words
  task automatic chk_msg(input logic [34:0] e, input logic [34:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED node rx expected %h seen %h", e, g);
    end
  endtask
  task automatic chk_reg(input string w, input logic [31:0] e,
                         input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  // APB transfer; pready, read data and error taken at one rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    @(posedge ref_clk_in);
    while (pready_out !== 1'b1) @(posedge ref_clk_in);
    r = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk_reg("register read", x, r & m);
  endtask
  // Poll status until an event bit is set, bounded
  task automatic wait_st(input int b);
    logic [31:0] r;
    logic e;
    int k;
    r = 32'h00000000;
    for (k = 0; k < 40 && r[b] !== 1'b1; k++) begin
      apb(1'b0, `FTMC_STATUS, 32'h0, r, e);
    end
    chk_reg("status event", 32'h00000001, {31'h0, r[b]});
  endtask
  // Offer one command to the node until it is taken
  task automatic send(input ftmc_pkg::ftmc_msg_t t, input logic [15:0] val);
    @(posedge ref_clk_in);
    cmd_vld_in <= 1'b1;
    cmd_type_in <= t;
    cmd_node_in <= n;
    cmd_orig_in <= o;
    cmd_flow_in <= f;
    cmd_val_in <= val;
    // Held until the rising edge at which ready is seen high
    @(posedge ref_clk_in);
    while (cmd_rdy_out !== 1'b1) @(posedge ref_clk_in);
    cmd_vld_in <= 1'b0;
  endtask
  task automatic wait_q;
    int k;
    for (k = 0; k < 60 && exp_q.size() > 0; k++) @(negedge ref_clk_in);
    chk_reg("pending node rx", 32'h0, exp_q.size());
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watch node receptions; oldest note is compared under its mask
  always @(negedge ref_clk_in) begin
    if (rx_vld_out === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk_msg(35'h0, {rx_type_out, rx_data_out});
      end else begin
        chk_msg(exp_q[0][66:32], {rx_type_out, rx_data_out & exp_q[0][31:0]});
        void'(exp_q.pop_front());
      end
    end
  end
  // Watchdog, well beyond the expected run
  initial begin
    #300000;
    n_mismatch++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(38107));
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    n = 8'($urandom());
    o = 8'($urandom());
    f = 8'($urandom());
    v = 16'($urandom());
    rd(`FTMC_MASK, 32'h0, ALL);
    rd(`FTMC_CNF_CODE, `FTMC_END_OK, ALL);
    wr(`FTMC_CNF_CODE, `FTMC_END_UNKNOWN);
    exp_q.push_back({ftmc_pkg::FTMC_END_CNF, 8'h0, `FTMC_END_UNKNOWN, f, o,
                     LOW3});
    send(ftmc_pkg::FTMC_END_REQ, {8'h0, `FTMC_RSN_NORMAL});
    wait_st(`FTMC_EV_END_REQ);
    rd(`FTMC_RX_TYPE, ftmc_pkg::FTMC_END_REQ, 32'h7);
    rd(`FTMC_RX_DATA, {`FTMC_RSN_NORMAL, f, o, n}, ALL);
    wait_q();
    chk_reg("irq masked", 32'h0, irq_out);
    // Interrupt flop follows the write edge, so look one edge later
    wr(`FTMC_MASK, 32'h1);
    @(posedge ref_clk_in);
    chk_reg("irq set", 32'h1, irq_out);
    wr(`FTMC_STATUS, 32'h3F);
    @(posedge ref_clk_in);
    chk_reg("irq cleared", 32'h0, irq_out);
    $display("test end request and irq done");
    send(ftmc_pkg::FTMC_BW_IND, v);
    wait_st(`FTMC_EV_BW_IND);
    rd(`FTMC_RX_DATA, {v[7:0], v[15:8], f, n}, ALL);
    exp_q.push_back({ftmc_pkg::FTMC_SHIFT_CNF, 16'h0, f, n, LOW3});
    send(ftmc_pkg::FTMC_SHIFT_REQ, ~v);
    wait_st(`FTMC_EV_SHIFT_REQ);
    rd(`FTMC_RX_DATA, {~v[7:0], ~v[15:8], f, n}, ALL);
    wait_q();
    $display("test bandwidth and shift done");
    for (int r = 1; r <= 4; r++) begin
      logic [7:0] rs;
      // Last pass: valid reason, but a reserved result in the answer
      rs = (r == 4) ? `FTMC_RSN_DISCON : r[7:0];
      wr(`FTMC_STATUS, 32'h3F);
      end_result_in <= r[7:0] - 8'h01;
      exp_q.push_back({ftmc_pkg::FTMC_END_REQ, rs, f, o, n, ALL});
      wr(`FTMC_TX_CMD, {rs, f, o, n});
      wait_q();
      wait_st(r == 4 ? `FTMC_EV_PROTO_ERR : `FTMC_EV_END_CNF);
      rd(`FTMC_RX_DATA, {8'h0, r[7:0] - 8'h1, f, o}, LOW3);
    end
    $display("test master end requests done");
    wr(`FTMC_STATUS, 32'h3F);
    wr(`FTMC_TX_CMD, {8'h04, f, o, n});
    wait_st(`FTMC_EV_PROTO_ERR);
    rd(`FTMC_TX_CMD, 32'h0, 32'h1);
    // Refusal pulse stands one cycle after the command is taken
    send(ftmc_pkg::FTMC_END_REQ, 16'h00FF);
    @(posedge ref_clk_in);
    chk_reg("cmd refused", 32'h1, {31'h0, cmd_err_out});
    send(ftmc_pkg::FTMC_SHIFT_CNF, 16'h0000);
    @(posedge ref_clk_in);
    chk_reg("bad type refused", 32'h1, {31'h0, cmd_err_out});
    apb(1'b0, 8'h18, 32'h0, rw, re);
    chk_reg("unmapped read", 32'h0, rw);
    chk_reg("unmapped error", 32'h1, {31'h0, re});
    $display("test reserved codes done");
    final_report();
  end
endmodule // tb_top
